// file: fcw_top.sv
// fetch-count watchdog: key registers, AHB-Lite slave, interrupt and counter
// Overview of operation
// - the watchdog runs while control bit 15 or the fuse enable is 1 and is idle while both are 0.
// - the software enable only matters when the fuse enable is 0; a set fuse forces running.
// - control bits 14 to 0 read 0 and ignore writes.
// - the preclear register keeps an 8-bit step-one key in bits 15:8, arming with 0x40.
// - the counter advances once per fetch while running and halts at a match.
// - the counter is 32 bits, matched against low and high 16-bit configuration words.
// - writing 0x08 as step-two key after a correct step-one key zeroes both keys and the counter.
// - any other step-two write sets the bad-clear flag, keeps step one, stores the value.
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fcw_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic fuse_enable,
    input wire logic [fcw_pkg::FCW_HALF_W-1:0] match_value_low,
    input wire logic [fcw_pkg::FCW_HALF_W-1:0] match_value_high,
    input wire logic fetch,
    output logic reset_request,
    output logic irq
);
    import fcw_pkg::*;

    // ----------------------------------------
    // bus address phase capture
    // ----------------------------------------
    logic wr_pend_r;
    logic [FCW_ADDR_W-1:0] addr_r;
    logic [31:0] hrdata_r;
    logic sw_enable_r;
    logic [FCW_KEY_W-1:0] preclear_key_r;
    logic [FCW_KEY_W-1:0] clear_key_r;
    logic bad_clear_flag_r;
    logic [FCW_IRQ_W-1:0] irq_stat_r;
    logic [FCW_IRQ_W-1:0] irq_mask_r;
    logic run;
    logic matched;
    logic rst_req;
    logic [FCW_CNT_W-1:0] count;

    wire addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire rd_go = addr_ph && !hwrite;
    wire [FCW_ADDR_W-1:0] a_now = haddr[FCW_ADDR_W-1:0];
    wire [FCW_KEY_W-1:0] wr_pre = hwdata[FCW_PRE_LSB +: FCW_KEY_W];
    wire [FCW_KEY_W-1:0] wr_clr = hwdata[FCW_CLR_LSB +: FCW_KEY_W];
    wire wr_ctrl = wr_pend_r && (addr_r == FCW_OFF_CTRL);
    wire wr_pre_go = wr_pend_r && (addr_r == FCW_OFF_PRECLR);
    wire wr_clr_go = wr_pend_r && (addr_r == FCW_OFF_CLR);
    wire wr_mask = wr_pend_r && (addr_r == FCW_OFF_IRQ_MASK);
    // step two only counts after an armed step one; anything else is a bad clear
    wire clr_ok = wr_clr_go && (wr_clr == FCW_CLR_KEY) && (preclear_key_r == FCW_PRE_KEY);
    wire clr_bad = wr_clr_go && !clr_ok;
    wire rd_stat = rd_go && (a_now == FCW_OFF_IRQ_STAT);

    // write data arrives one cycle after its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= '0;
        end else begin
            wr_pend_r <= addr_ph && hwrite;
            if (addr_ph) begin
                addr_r <= a_now;
            end
        end
    end

    // zero-wait slave, always OKAY; unmapped reads give 0, writes are dropped
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ----------------------------------------
    // control and keys
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            sw_enable_r <= hwdata[FCW_EN_BIT];
        end
    end

    // a set fuse overrides the software bit, which then only reads back
    assign run = fuse_enable || sw_enable_r;

    // ----------------------------------------
    // clear key sequence
    // ----------------------------------------
    // a match acts as the watchdog reset event and wipes both keys
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preclear_key_r <= FCW_KEY_RST;
        end else if (rst_req || clr_ok) begin
            preclear_key_r <= FCW_KEY_RST;
        end else if (wr_pre_go) begin
            preclear_key_r <= wr_pre;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clear_key_r <= FCW_KEY_RST;
        end else if (rst_req || clr_ok) begin
            clear_key_r <= FCW_KEY_RST;
        end else if (wr_clr_go) begin
            clear_key_r <= wr_clr;
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // bad flag: hardware set wins over a reading clear
    wire rd_status = rd_go && (a_now == FCW_OFF_STATUS);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_clear_flag_r <= 1'b0;
        end else if (clr_bad) begin
            bad_clear_flag_r <= 1'b1;
        end else if (rd_status || rst_req) begin
            bad_clear_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [FCW_IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[FCW_ST_BAD] = clr_bad;
        ev[FCW_ST_EVT] = rst_req;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
        end else begin
            // an event in the cycle of the clearing read is kept
            irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_r <= '0;
        end else if (wr_mask) begin
            irq_mask_r <= hwdata[FCW_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // picked in the address phase: a read in a write's data phase still sees the old value
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = '0;
        case (a_now)
            FCW_OFF_CTRL: rd_nxt[FCW_EN_BIT] = sw_enable_r;
            FCW_OFF_PRECLR: rd_nxt[FCW_PRE_LSB +: FCW_KEY_W] = preclear_key_r;
            FCW_OFF_CLR: rd_nxt[FCW_CLR_LSB +: FCW_KEY_W] = clear_key_r;
            FCW_OFF_STATUS: begin
                rd_nxt[FCW_ST_BAD] = bad_clear_flag_r;
                rd_nxt[FCW_ST_EVT] = matched;
                rd_nxt[FCW_ST_RUN] = run;
            end
            FCW_OFF_IRQ_STAT: rd_nxt[FCW_IRQ_W-1:0] = irq_stat_r;
            FCW_OFF_IRQ_MASK: rd_nxt[FCW_IRQ_W-1:0] = irq_mask_r;
            FCW_OFF_CNT_LO: rd_nxt[FCW_HALF_W-1:0] = count[FCW_HALF_W-1:0];
            FCW_OFF_CNT_HI: rd_nxt[FCW_HALF_W-1:0] = count[FCW_CNT_W-1:FCW_HALF_W];
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (rd_go) begin
            // held between reads; only a read address phase reloads it
            hrdata_r <= rd_nxt;
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    fcw_counter #(
        .CNT_W(FCW_CNT_W)
    ) u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .fetch(fetch),
        .clear(clr_ok),
        .match_val({match_value_high, match_value_low}),
        .count(count),
        .matched(matched),
        .rst_req(rst_req)
    );

    // the pulse doubles as the reset event that wipes keys and bad flag
    assign reset_request = rst_req;
endmodule
`default_nettype wire

// file: fcw_pkg.sv
// package: register map, key patterns and field layout of the fetch-count watchdog
package fcw_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] FCW_OFF_CTRL = 8'h00;
    localparam logic [7:0] FCW_OFF_PRECLR = 8'h04;
    localparam logic [7:0] FCW_OFF_CLR = 8'h08;
    localparam logic [7:0] FCW_OFF_STATUS = 8'h0C;
    localparam logic [7:0] FCW_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] FCW_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] FCW_OFF_CNT_LO = 8'h18;
    localparam logic [7:0] FCW_OFF_CNT_HI = 8'h1C;
    localparam int FCW_ADDR_W = 8;
    // ----------------------------------------
    // fields and keys
    // ----------------------------------------
    localparam int FCW_EN_BIT = 15;
    localparam int FCW_KEY_W = 8;
    localparam int FCW_PRE_LSB = 8;
    localparam int FCW_CLR_LSB = 0;
    localparam logic [7:0] FCW_PRE_KEY = 8'h40;
    localparam logic [7:0] FCW_CLR_KEY = 8'h08;
    localparam logic [7:0] FCW_KEY_RST = 8'h00;
    localparam int FCW_CNT_W = 32;
    localparam int FCW_HALF_W = 16;
    // status / interrupt bits
    localparam int FCW_ST_BAD = 0;
    localparam int FCW_ST_EVT = 1;
    localparam int FCW_ST_RUN = 2;
    localparam int FCW_IRQ_W = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// file: fcw_counter.sv
// fetch counter with match detection and single-cycle reset request
`timescale 1ns/1ps
`default_nettype none
module fcw_counter #(
    parameter int CNT_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic fetch,
    input wire logic clear,
    input wire logic [CNT_W-1:0] match_val,
    output logic [CNT_W-1:0] count,
    output logic matched,
    output logic rst_req
);
    logic [CNT_W-1:0] count_r;
    logic matched_r;
    logic rst_req_r;
    wire hit = run && !matched_r && (count_r == match_val);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= '0;
        end else if (clear) begin
            count_r <= '0;
        end else if (run && fetch && !matched_r && !hit) begin
            count_r <= count_r + 1'b1;
        end
    end

    // match latches until the clear sequence; counting halts there
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            matched_r <= 1'b0;
        end else if (clear) begin
            matched_r <= 1'b0;
        end else if (hit) begin
            matched_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_req_r <= 1'b0;
        end else begin
            rst_req_r <= hit;
        end
    end

    assign count = count_r;
    assign matched = matched_r;
    assign rst_req = rst_req_r;
endmodule
`default_nettype wire

// file: fcw_checker.sv
// checker: bus and key-register properties of the watchdog slave
`timescale 1ns/1ps
`default_nettype none
module fcw_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic reset_request,
    input wire logic irq
);
    import fcw_pkg::*;
    logic rd_q, wr_q, en_q;
    logic [7:0] a_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            rd_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
            wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
            a_q <= haddr[7:0];
        end
    end
    // expected enable as last written by software; a read captures it at its address edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) en_q <= 1'b0;
        else if (wr_q && a_q == FCW_OFF_CTRL) en_q <= hwdata[FCW_EN_BIT];
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    zero_wait_a: assert property (hreadyout && !hresp) else $error("stall or error seen");
    req_single_a: assert property (reset_request |=> !reset_request) else $error("long req");
    ctrl_enable_a: assert property (rd_q && a_q == FCW_OFF_CTRL |->
        hrdata[15] == $past(en_q)) else $error("enable readback wrong");
    ctrl_unused_a: assert property (rd_q && a_q == FCW_OFF_CTRL |-> hrdata[14:0] == 15'h0000)
        else $error("control low bits not zero");
    pre_low_a: assert property (rd_q && a_q == FCW_OFF_PRECLR |-> hrdata[7:0] == 8'h00)
        else $error("preclear low bits not zero");
    clr_high_a: assert property (rd_q && a_q == FCW_OFF_CLR |-> hrdata[31:8] == 24'h000000)
        else $error("clear high bits not zero");
    unmapped_zero_a: assert property (rd_q && a_q >= 8'h20 |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property ($rose(hresetn) |-> !irq && !reset_request)
        else $error("outputs active after reset");
    cover property (reset_request);
    cover property (irq);
    cover property (rd_q && a_q == FCW_OFF_CLR);
endmodule
bind fcw_top fcw_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .reset_request(reset_request), .irq(irq));
`default_nettype wire

// file: tb_fcw_top.sv
// testbench: register, key-sequence and counter checks of the watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_fcw_top;
    import fcw_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, reset_request, irq;
    logic [31:0] hrdata;
    logic fuse_enable = 1'b0;
    logic fetch = 1'b0;
    logic [15:0] mv_lo = 16'hFFFF;
    logic [15:0] mv_hi = 16'hFFFF;
    int err_total = 0;
    int tests_run = 0;
    int pulses = 0;
    always #25 hclk = ~hclk;
    // counted mid-cycle so the registered pulse has settled
    always @(negedge hclk) if (reset_request === 1'b1) pulses++;
    fcw_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_enable(fuse_enable),
        .match_value_low(mv_lo), .match_value_high(mv_hi), .fetch(fetch),
        .reset_request(reset_request), .irq(irq));
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic edge_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                err_total++;
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        r = hrdata;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk($sformatf("reg %h", a), e, r);
    endtask
    task automatic run_fetch(int n);
        fetch <= 1'b1;
        repeat (n) @(posedge hclk);
        fetch <= 1'b0;
        @(posedge hclk);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(FCW_OFF_CTRL, 32'h0);
        rd(FCW_OFF_PRECLR, 32'h0);
        rd(FCW_OFF_CLR, 32'h0);
        rd(8'h20, 32'h0);
        wr(FCW_OFF_CTRL, 32'hFFFF);
        rd(FCW_OFF_CTRL, 32'h8000);
        wr(FCW_OFF_IRQ_MASK, 32'h3);
        run_fetch(10);
        rd(FCW_OFF_CNT_LO, 32'h0000000A);
        wr(FCW_OFF_CTRL, 32'h0);
        run_fetch(4);
        rd(FCW_OFF_CNT_LO, 32'h0000000A);
        fuse_enable <= 1'b1;
        run_fetch(3);
        rd(FCW_OFF_CNT_LO, 32'h0000000D);
        fuse_enable <= 1'b0;
        wr(FCW_OFF_PRECLR, 32'h40FF);
        rd(FCW_OFF_PRECLR, 32'h4000);
        wr(FCW_OFF_CLR, 32'hFF5A);
        rd(FCW_OFF_CLR, 32'h5A);
        rd(FCW_OFF_PRECLR, 32'h4000);
        rd(FCW_OFF_STATUS, 32'h1);
        rd(FCW_OFF_STATUS, 32'h0);
        chk("irq", 32'h1, {31'h0, irq});
        rd(FCW_OFF_IRQ_STAT, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(FCW_OFF_CLR, 32'h8);
        rd(FCW_OFF_PRECLR, 32'h0);
        rd(FCW_OFF_CLR, 32'h0);
        rd(FCW_OFF_CNT_LO, 32'h0);
        wr(FCW_OFF_CLR, 32'h8);
        rd(FCW_OFF_IRQ_STAT, 32'h1);
        mv_lo <= 16'h0005;
        mv_hi <= 16'h0000;
        wr(FCW_OFF_PRECLR, 32'h4000);
        wr(FCW_OFF_CTRL, 32'h8000);
        run_fetch(8);
        chk("pulses", 32'h00000001, pulses);
        chk("irq", 32'h1, {31'h0, irq});
        rd(FCW_OFF_CNT_LO, 32'h5);
        rd(FCW_OFF_CNT_HI, 32'h0);
        rd(FCW_OFF_STATUS, 32'h6);
        rd(FCW_OFF_PRECLR, 32'h0);
        rd(FCW_OFF_IRQ_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        print_verdict();
    end
endmodule
`default_nettype wire
